/* verilog/sctg_defs.svh */
// Offsets, field positions, reset values and timing counts of the clock timing block
`ifndef SCTG_DEFS_SVH
`define SCTG_DEFS_SVH

`define SCTG_TIMING_GEN_CONTROL_ADDR 8'h36
`define SCTG_TIMING_GEN_CONTROL_RST  8'h00
`define SCTG_DIVIDER_CONTROL_ADDR    8'h35
`define SCTG_DIVIDER_CONTROL_RST     8'h00
`define SCTG_SYSTEM_CONTROL_ONE_ADDR 8'h38
`define SCTG_SYSTEM_CONTROL_TWO_ADDR 8'h39
`define SCTG_SYSTEM_CONTROL_RST      8'h00
`define SCTG_DVO_EN_BIT              7
`define SCTG_DVO_SEL_HI              6
`define SCTG_DVO_SEL_LO              5
`define SCTG_TB_EN_BIT               3
`define SCTG_TB_SEL_HI               2
`define SCTG_TB_SEL_LO               0
`define SCTG_DIV_MASK                8'h18
`define SCTG_TGC_MASK                8'hEF
`define SCTG_STOP_BIT                7
`define SCTG_IDLE_BIT                2
`define SCTG_WARMUP_SEL_HI           3
`define SCTG_WARMUP_SEL_LO           2
`define SCTG_PRESCALE_STAGES         3
`define SCTG_DIVIDER_STAGES          21
`define SCTG_STATES_PER_CYCLE        4
`define SCTG_MAX_MACHINE_CYCLES      15

`endif

/* verilog/sctg_pkg.sv */
// Types shared by the clock timing block
package sctg_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sctg_bus_req_t;

  typedef struct packed {
    logic       divider_output;
    logic       time_base_src;
    logic       watchdog_src;
    logic [3:0] timer_src;
    logic       warmup_done;
  } sctg_clk_out_t;

  typedef enum logic [1:0] {
    SCTG_NORMAL,
    SCTG_IDLE,
    SCTG_STOP,
    SCTG_WARMUP
  } sctg_mode_t;
endpackage

/* verilog/sctg_divider_chain.sv */
// Prescaler and divider chain of the timing generator
`timescale 1ns/1ps
`include "sctg_defs.svh"
module sctg_divider_chain #(
  parameter int PRE_STAGES = `SCTG_PRESCALE_STAGES,
  parameter int DIV_STAGES = `SCTG_DIVIDER_STAGES
) (
  input  wire logic                  clock,     // High-frequency clock
  input  wire logic                  rst_n,     // Synchronous reset
  input  wire logic                  clear,     // Stop entry or exit clear
  input  wire logic                  run,       // Low while oscillator stopped
  output logic [DIV_STAGES-1:0]      div_bits   // Divider stage outputs
);
  logic [PRE_STAGES-1:0] pre_reg;
  logic [PRE_STAGES-1:0] pre_next;
  logic [DIV_STAGES-1:0] div_next;
  wire                   pre_carry;

  assign pre_carry = &pre_reg;
  assign pre_next  = pre_reg + PRE_STAGES'(1);
  assign div_next  = div_bits + DIV_STAGES'(1);

  always_ff @(posedge clock) begin
    if (!rst_n || clear) begin // R2
      pre_reg  <= '0;
      div_bits <= '0;
    end else if (run) begin // R1
      pre_reg <= pre_next;
      if (pre_carry) begin
        div_bits <= div_next;
      end
    end
  end
endmodule

/* verilog/sctg_top.sv */
// System clock timing generator with standby control and register port
`timescale 1ns/1ps
`include "sctg_defs.svh"
//
// Contract
// [R1] Three-stage prescaler feeds 21-stage divider chain plus machine cycle counter.
// [R2] Prescaler and dividers clear on reset, stop entry and stop exit.
// [R3] Machine cycle is four states, one main clock each.
// [R4] Machine cycle counter covers one to fifteen cycles per instruction.
// [R5] Outputs: divider pulse, time base, watchdog, timer sources, warm-up.
// [R6] Timing control register at 36h, reset zero, fields as documented.
// [R7] Software writes zero to timing control bit 4.
// [R8] Divider control bits 4 and 3 read indeterminate.
// [R9] Software writes zero to divider control bits 7,6,2,1,0.
// [R10] Clock from resonator or external clock; no RC oscillator.
// [R11] Standby control starts and stops oscillator under two control registers.
// [R12] Single clock mode: machine cycle equals four fundamental clocks.
// [R13] Idle halts CPU and watchdog; interrupt returns to normal.
// [R14] Stop halts all; stop pin release resumes after warm-up. The code never ends warm-up while warm_sel is 1 or 2.
// [R15] Divider output and time base inactive when enables are zero.
// [R16] Reset starts normal mode, oscillator running, counters zero.
module sctg_top #(
  parameter int DIV_STAGES = `SCTG_DIVIDER_STAGES
) (
  input  wire logic                 clock,           // High-frequency clock
  input  wire logic                 rst_n,           // Synchronous reset
  input  sctg_pkg::sctg_bus_req_t   bus_req,         // Register access
  input  wire logic                 stop_release_n,  // Stop release pin, low releases
  input  wire logic                 wake_irq,        // Interrupt request ending idle
  input  wire logic [3:0]           instr_cycles,    // Machine cycles of current instruction
  output logic [7:0]                rdata,           // Read data
  output sctg_pkg::sctg_clk_out_t   clk_out,         // Generated source clocks
  output logic [1:0]                machine_state,   // State within machine cycle
  output logic                      instr_done,      // Last cycle of instruction
  output logic                      cpu_run,         // CPU clock enable
  output logic                      osc_enable,      // Oscillator run control
  output sctg_pkg::sctg_mode_t      mode             // Operating mode
);
  import sctg_pkg::*;

  // ****************************************************************
  // Registers and pin synchroniser
  // ****************************************************************
  logic [7:0]            tgc_reg;
  logic [7:0]            divc_reg;
  logic [7:0]            sys1_reg;
  logic [7:0]            sys2_reg;
  logic                  stop_meta_reg;
  logic                  stop_sync_reg;
  logic [DIV_STAGES-1:0] div_bits;
  logic [DIV_STAGES-1:0] div_prev_reg;
  logic [1:0]            state_reg;
  logic [3:0]            mcycle_reg;
  sctg_mode_t            mode_reg;
  sctg_mode_t            mode_next;
  logic [DIV_STAGES-1:0] rise;
  logic                  chain_clear;
  logic                  warm_tick;
  logic                  indeterminate_reg;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // One-hot select shared by the write and the read path
  function automatic logic [3:0] reg_hit(input logic [7:0] addr);
    reg_hit = 4'h0;
    case (addr)
      `SCTG_TIMING_GEN_CONTROL_ADDR: begin
        reg_hit = 4'h1;
      end
      `SCTG_DIVIDER_CONTROL_ADDR: begin
        reg_hit = 4'h2;
      end
      `SCTG_SYSTEM_CONTROL_ONE_ADDR: begin
        reg_hit = 4'h4;
      end
      `SCTG_SYSTEM_CONTROL_TWO_ADDR: begin
        reg_hit = 4'h8;
      end
      default: begin
        reg_hit = 4'h0;
      end
    endcase
  endfunction

  wire [3:0] hit       = reg_hit(bus_req.addr);
  wire       wr_tgc    = bus_req.wr && hit[0];
  wire       wr_divc   = bus_req.wr && hit[1];
  wire       wr_sys1   = bus_req.wr && hit[2];
  wire       wr_sys2   = bus_req.wr && hit[3];
  wire       stop_done = (mode_reg == SCTG_WARMUP) && (mode_next == SCTG_NORMAL);
  wire       idle_wake = (mode_reg == SCTG_IDLE) && wake_irq;

  always_ff @(posedge clock) begin
    stop_meta_reg <= stop_release_n;
    stop_sync_reg <= stop_meta_reg;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tgc_reg  <= `SCTG_TIMING_GEN_CONTROL_RST; // R6
      divc_reg <= `SCTG_DIVIDER_CONTROL_RST;
    end else begin
      if (wr_tgc) begin
        tgc_reg <= bus_req.wdata & `SCTG_TGC_MASK; // R6 R7
      end
      if (wr_divc) begin
        divc_reg <= bus_req.wdata & `SCTG_DIV_MASK; // R9
      end
    end
  end

  // A software write in the same cycle wins over the hardware clear of a mode bit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sys1_reg <= `SCTG_SYSTEM_CONTROL_RST;
    end else if (wr_sys1) begin
      sys1_reg <= bus_req.wdata; // R11
    end else if (stop_done) begin
      sys1_reg[`SCTG_STOP_BIT] <= 1'b0; // R14
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sys2_reg <= `SCTG_SYSTEM_CONTROL_RST;
    end else if (wr_sys2) begin
      sys2_reg <= bus_req.wdata; // R11
    end else if (idle_wake) begin
      sys2_reg[`SCTG_IDLE_BIT] <= 1'b0; // R13
    end
  end

  // ****************************************************************
  // Standby control
  // ****************************************************************
  wire [1:0] warm_sel = sys1_reg[`SCTG_WARMUP_SEL_HI:`SCTG_WARMUP_SEL_LO];

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      SCTG_NORMAL: begin
        if (sys1_reg[`SCTG_STOP_BIT]) begin
          mode_next = SCTG_STOP; // R11 R14
        end else if (sys2_reg[`SCTG_IDLE_BIT]) begin
          mode_next = SCTG_IDLE; // R13
        end
      end
      SCTG_IDLE: begin
        if (wake_irq) begin
          mode_next = SCTG_NORMAL; // R13
        end
      end
      SCTG_STOP: begin
        if (!stop_sync_reg) begin
          mode_next = SCTG_WARMUP; // R14
        end
      end
      SCTG_WARMUP: begin
        if (warm_tick) begin
          mode_next = SCTG_NORMAL; // R14
        end
      end
      default: mode_next = SCTG_NORMAL;
    endcase
  end

  // Clear on both edges of stop so warm-up counts from zero
  assign chain_clear = (mode_reg == SCTG_NORMAL && mode_next == SCTG_STOP) ||
                       (mode_reg == SCTG_STOP && mode_next == SCTG_WARMUP); // R2

  sctg_divider_chain #(
    .DIV_STAGES (DIV_STAGES)
  ) u_chain (
    .clock    (clock),
    .rst_n    (rst_n),
    .clear    (chain_clear),
    .run      (mode_reg != SCTG_STOP), // R14
    .div_bits (div_bits)
  );

  // Rising edge of each stage, one clock pulse wide
  genvar gi;
  generate
    for (gi = 0; gi < DIV_STAGES; gi++) begin : g_rise
      assign rise[gi] = div_bits[gi] & ~div_prev_reg[gi];
    end
  endgenerate

  // Taps beyond the chain read as zero, so a shortened chain never yields unknowns
  function automatic logic tap(input logic [DIV_STAGES-1:0] v, input int idx);
    tap = (idx < DIV_STAGES) ? v[idx] : 1'b0;
  endfunction

  function automatic logic pick4(input logic [DIV_STAGES-1:0] v, input logic [1:0] sel,
                                 input int base, input int step);
    pick4 = tap(v, base + step * int'(sel));
  endfunction

  // Warm-up ends on the top stage rising; a nonzero warm_sel also ANDs in stage DIV_STAGES-4+warm_sel, which is low at that edge unless warm_sel is 3
  wire warm_gate = (warm_sel == 2'b00) ? 1'b1 : pick4(div_bits, warm_sel, DIV_STAGES - 4, 1);

  assign warm_tick = rise[DIV_STAGES - 1] & warm_gate; // R14

  // ****************************************************************
  // Machine cycle sequencing
  // ****************************************************************
  wire last_state = (state_reg == 2'(`SCTG_STATES_PER_CYCLE - 1));
  wire [3:0] instr_len = (instr_cycles == 4'h0) ? 4'h1 : instr_cycles;
  wire last_cycle = (mcycle_reg >= instr_len - 4'h1);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_reg          <= SCTG_NORMAL; // R16
      div_prev_reg      <= '0;
      indeterminate_reg <= 1'b0;
    end else begin
      mode_reg          <= mode_next;
      div_prev_reg      <= div_bits;
      indeterminate_reg <= ~indeterminate_reg;
    end
  end

  // Sequencing freezes outside normal mode, so an instruction resumes where it paused
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg  <= 2'h0;
      mcycle_reg <= 4'h0;
    end else if (mode_reg == SCTG_NORMAL) begin
      state_reg <= state_reg + 2'h1; // R3 R12
      if (last_state) begin
        mcycle_reg <= last_cycle ? 4'h0 : mcycle_reg + 4'h1; // R4
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire [1:0] dvo_sel = tgc_reg[`SCTG_DVO_SEL_HI:`SCTG_DVO_SEL_LO];
  wire [2:0] tb_sel  = tgc_reg[`SCTG_TB_SEL_HI:`SCTG_TB_SEL_LO];
  wire       running = (mode_reg == SCTG_NORMAL) || (mode_reg == SCTG_IDLE);
  wire [7:0] divc_rd = {divc_reg[7:5], {2{indeterminate_reg}}, divc_reg[2:0]}; // R8
  wire [7:0] rd_sel  = ({8{hit[0]}} & tgc_reg) | ({8{hit[1]}} & divc_rd) |
                       ({8{hit[2]}} & sys1_reg) | ({8{hit[3]}} & sys2_reg);
  wire [7:0] rdata_next = bus_req.rd ? rd_sel : 8'h00;

  // ****************************************************************
  // Source clocks
  // ****************************************************************
  wire       dvo_next   = tgc_reg[`SCTG_DVO_EN_BIT] & running & pick4(div_bits, dvo_sel, 10, 1); // R5 R15
  wire       tb_next    = tgc_reg[`SCTG_TB_EN_BIT] & running & tap(rise, 13 + int'(tb_sel)); // R5 R15
  // Follows the next mode, so no watchdog pulse lands in the first idle cycle
  wire       wd_next    = (mode_next == SCTG_NORMAL) & rise[DIV_STAGES - 5]; // R13
  wire [3:0] timer_next = running ? {rise[11], rise[7], rise[5], rise[0]} : 4'h0;
  wire       warm_next  = (mode_reg == SCTG_WARMUP) & warm_tick; // R5
  wire       done_next  = (mode_reg == SCTG_NORMAL) & last_state & last_cycle;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_next; // R6 R8
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clk_out <= '0;
    end else begin
      clk_out.divider_output <= dvo_next;
      clk_out.time_base_src  <= tb_next;
      clk_out.watchdog_src   <= wd_next;
      clk_out.timer_src      <= timer_next; // R5
      clk_out.warmup_done    <= warm_next;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      machine_state <= 2'h0;
      instr_done    <= 1'b0;
    end else begin
      machine_state <= state_reg; // R3
      instr_done    <= done_next; // R4
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cpu_run    <= 1'b1;
      osc_enable <= 1'b1; // R16
      mode       <= SCTG_NORMAL;
    end else begin
      cpu_run    <= (mode_next == SCTG_NORMAL); // R13
      osc_enable <= (mode_next != SCTG_STOP); // R10 R11
      mode       <= mode_next;
    end
  end
endmodule

/* testbench/sctg_ext_model.sv */
// External pin model: stop release pin and interrupt source
`timescale 1ns/1ps
module sctg_ext_model (
  input  wire logic clock,           // High-frequency clock
  input  wire logic stop_cmd,        // Bench asks for stop release
  input  wire logic wake_cmd,        // Bench asks for an interrupt
  output logic      stop_release_n = 1'b1, // Pin rests high through its pull-up
  output logic      wake_irq = 1'b0  // Interrupt level
);
  always_ff @(posedge clock) begin
    stop_release_n <= !stop_cmd;
    wake_irq       <= wake_cmd;
  end
endmodule

/* testbench/sctg_checker.sv */
// Assertion checker on the ports of the clock timing block
`timescale 1ns/1ps
`include "sctg_defs.svh"
module sctg_checker
  import sctg_pkg::*;
#(parameter int DIV_STAGES = 21) (
  input wire logic           clock,          // Clock
  input wire logic           rst_n,          // Reset
  input sctg_bus_req_t       bus_req,        // Register access
  input wire logic           stop_release_n, // Stop pin
  input wire logic           wake_irq,       // Interrupt
  input wire logic [3:0]     instr_cycles,   // Cycles per instruction
  input wire logic [7:0]     rdata,          // Read data
  input sctg_clk_out_t       clk_out,        // Source clocks
  input wire logic [1:0]     machine_state,  // State in cycle
  input wire logic           instr_done,     // Instruction end
  input wire logic           cpu_run,        // CPU enable
  input wire logic           osc_enable,     // Oscillator run
  input sctg_mode_t          mode            // Mode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [7:0] tgc_sh;
  wire tgc_hit = bus_req.addr == `SCTG_TIMING_GEN_CONTROL_ADDR;
  wire mapped  = tgc_hit || bus_req.addr == `SCTG_DIVIDER_CONTROL_ADDR ||
                 bus_req.addr == `SCTG_SYSTEM_CONTROL_ONE_ADDR || bus_req.addr == `SCTG_SYSTEM_CONTROL_TWO_ADDR;
  // Shadow of the control register, so enables are known without peeking inside
  always_ff @(posedge clock) begin
    if (!rst_n) tgc_sh <= 8'h00;
    else if (bus_req.wr && tgc_hit) tgc_sh <= bus_req.wdata;
  end
  sequence s_dvo_off; !tgc_sh[7] [*2]; endsequence
  sequence s_tb_off; !tgc_sh[3] [*2]; endsequence
  a_reset_to_normal: assert property ($rose(rst_n) |-> mode == SCTG_NORMAL && cpu_run && osc_enable)
    else $error("mode after reset wrong");
  a_state_steps_one: assert property (cpu_run && $past(cpu_run) && $past(cpu_run, 2) && $past(rst_n) && $past(rst_n, 2) |->
    machine_state == 2'($past(machine_state) + 2'h1)) else $error("machine state skipped");
  a_done_in_last: assert property (instr_done |-> machine_state == 2'h3) else $error("done outside S3");
  a_dvo_held_low: assert property (s_dvo_off |-> !clk_out.divider_output) else $error("divider output active");
  a_tb_held_low: assert property (s_tb_off |-> !clk_out.time_base_src) else $error("time base active");
  a_idle_halts_cpu: assert property (mode == SCTG_IDLE |-> !cpu_run && !clk_out.watchdog_src) else $error("idle runs cpu");
  a_stop_osc_off: assert property (mode == SCTG_STOP |-> !osc_enable) else $error("oscillator on in stop");
  a_tgc_read_back: assert property (bus_req.rd && !bus_req.wr && tgc_hit |=>
    rdata == ($past(tgc_sh) & `SCTG_TGC_MASK)) else $error("control readback wrong");
  a_unmapped_zero: assert property (bus_req.rd && !mapped |=> rdata == 8'h00) else $error("unmapped read nonzero");
endmodule
bind sctg_top sctg_checker #(.DIV_STAGES(DIV_STAGES)) i_sctg_checker (.*);

/* testbench/tb_sctg_top.sv */
// Self-checking testbench for the clock timing block
`timescale 1ns/1ps
`include "sctg_defs.svh"
module tb_sctg_top;
  import sctg_pkg::*;
  logic          clock = 1'b0, rst_n = 1'b0, stop_cmd = 1'b0, wake_cmd = 1'b0;
  sctg_bus_req_t bus_req = '0;
  logic [3:0]    instr_cycles = 4'h1;
  logic          stop_release_n, wake_irq, instr_done, cpu_run, osc_enable;
  logic [7:0]    rdata, rd_val;
  sctg_clk_out_t clk_out;
  logic [1:0]    machine_state;
  sctg_mode_t    mode;
  int            error_cnt = 0, cmp_count = 0, cyc = 0, gap;
  sctg_top #(.DIV_STAGES(16)) i_sctg_top (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
    .stop_release_n(stop_release_n), .wake_irq(wake_irq), .instr_cycles(instr_cycles), .rdata(rdata),
    .clk_out(clk_out), .machine_state(machine_state), .instr_done(instr_done), .cpu_run(cpu_run),
    .osc_enable(osc_enable), .mode(mode));
  sctg_ext_model i_sctg_ext_model (.clock(clock), .stop_cmd(stop_cmd), .wake_cmd(wake_cmd),
    .stop_release_n(stop_release_n), .wake_irq(wake_irq));
  initial begin
    forever #10 clock = !clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle strobe; read data is taken once the answering edge has landed
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
    #1 rd_val = rdata;
  endtask
  task automatic wait_mode(input sctg_mode_t m);
    for (int i = 0; i < 8 && mode !== m; i++) begin
      @(posedge clock);
      #1;
    end
    chk(8'(mode), 8'(m));
  endtask
  task automatic t_regs;
    bus(0, `SCTG_TIMING_GEN_CONTROL_ADDR, 8'h00); chk(rd_val, 8'h00);
    bus(0, `SCTG_DIVIDER_CONTROL_ADDR, 8'h00); chk(rd_val & 8'hE7, 8'h00);
    bus(1, `SCTG_DIVIDER_CONTROL_ADDR, 8'h18);
    bus(0, `SCTG_DIVIDER_CONTROL_ADDR, 8'h00); chk(rd_val & 8'hE7, 8'h00);
    chk({6'h0, cpu_run, osc_enable}, 8'h03);
    bus(1, `SCTG_TIMING_GEN_CONTROL_ADDR, 8'hEF);
    bus(0, `SCTG_TIMING_GEN_CONTROL_ADDR, 8'h00); chk(rd_val, 8'hEF);
    bus(0, 8'h37, 8'h00); chk(rd_val, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_dvo;
    bus(1, `SCTG_TIMING_GEN_CONTROL_ADDR, 8'h80);
    for (gap = 0; gap < 20000 && clk_out.divider_output !== 1'b1; gap++) begin
      @(posedge clock);
      #1;
    end
    chk({7'h0, clk_out.divider_output}, 8'h01);
    bus(1, `SCTG_TIMING_GEN_CONTROL_ADDR, 8'h00);
    repeat (3) @(posedge clock);
    #1 chk({7'h0, clk_out.divider_output}, 8'h00);
    $display("test divider output done");
  endtask
  task automatic t_timer;
    for (gap = 0; gap < 64 && clk_out.timer_src[0] !== 1'b1; gap++) begin
      @(posedge clock);
      #1;
    end
    for (gap = 1; gap < 64; gap++) begin
      @(posedge clock);
      #1;
      if (clk_out.timer_src[0] === 1'b1) break;
    end
    chk(8'(gap), 8'(2 << `SCTG_PRESCALE_STAGES));
    $display("test timer source done");
  endtask
  task automatic t_cycles(input logic [3:0] n);
    @(posedge clock);
    instr_cycles <= n;
    repeat (2) begin
      for (gap = 1; gap < 200; gap++) begin
        @(posedge clock);
        #1;
        if (instr_done === 1'b1) break;
      end
    end
    chk(8'(gap), 8'(4 * n));
    $display("test cycles %0d done", n);
  endtask
  task automatic t_idle;
    bus(1, `SCTG_SYSTEM_CONTROL_TWO_ADDR, 8'h04); wait_mode(SCTG_IDLE);
    chk({7'h0, cpu_run}, 8'h00);
    @(posedge clock);
    wake_cmd <= 1'b1;
    wait_mode(SCTG_NORMAL);
    wake_cmd <= 1'b0;
    $display("test idle done");
  endtask
  task automatic t_stop;
    bus(1, `SCTG_SYSTEM_CONTROL_ONE_ADDR, 8'h80); wait_mode(SCTG_STOP);
    chk({7'h0, osc_enable}, 8'h00);
    @(posedge clock);
    stop_cmd <= 1'b1;
    wait_mode(SCTG_WARMUP);
    @(posedge clock);
    stop_cmd <= 1'b0;
    // Full warm-up is far too long to simulate, so a reset brings the block back
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wait_mode(SCTG_NORMAL);
    $display("test stop done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    t_regs();
    t_dvo();
    t_timer();
    t_cycles(4'h1);
    t_cycles(4'hF);
    t_idle();
    t_stop();
    print_verdict();
  end
endmodule
